// File: core/spi_port_defines.svh
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// ==========================================================
// Register word addresses
`define SPI_ADDR_CTRL 2'h0
`define SPI_ADDR_CFG 2'h1
`define SPI_ADDR_DATA 2'h2
`define SPI_ADDR_RATE 2'h3

// ==========================================================
// Field positions of control_reg
`define SPI_CTRL_DONE 7
`define SPI_CTRL_WRITE_COLLISION_FLAG 6
`define SPI_CTRL_MODE_FAULT_FLAG 5
`define SPI_CTRL_OVRN 4
`define SPI_CTRL_MODE_HI 3
`define SPI_CTRL_MODE_LO 2
`define SPI_CTRL_IRQEN 1
`define SPI_CTRL_EN 0

// ==========================================================
// Field positions of the configuration register
`define SPI_CFG_BUSY 7
`define SPI_CFG_MASTER_ENABLE 6
`define SPI_CFG_CPHA 5
`define SPI_CFG_CPOL 4
`define SPI_CFG_SLVSEL 3
`define SPI_CFG_SELIN 2
`define SPI_CFG_SRMT 1
`define SPI_CFG_RXBMT 0

// ==========================================================
// Select pin modes, reset values, bit counts
`define SPI_MODE_3WIRE 2'b00
`define SPI_MODE_MULTI 2'b01
`define SPI_MODE_RESET 2'b01
`define SPI_RATE_RESET 8'h00
`define SPI_BYTE_RESET 8'h00
`define SPI_BIT_LAST 4'h7
`define SPI_BIT_FULL 4'h8

`endif

// File: core/spi_port_pkg.sv
package spi_port_pkg;

   // Sticky event flags, set by hardware, cleared by software
   typedef struct packed {
      logic xferDone;
      logic writeColl;
      logic modeFault;
      logic rxOverrun;
   } flags_s;

   // Master sequencer states
   typedef enum logic [1:0] {
      M_IDLE = 2'b01,
      M_RUN = 2'b10
   } mstate_e;

endpackage

// File: core/spi_master_slave_port.sv
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "spi_port_defines.svh"
module spi_master_slave_port #(
   parameter int ADDR_W = 2,
   parameter int DIV_W = 8
) (
   input wire logic core_clk, // System clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic clkEn, // Freezes all state while low
   input wire logic [ADDR_W-1:0] regAddr, // Register word address
   input wire logic [7:0] wrData, // Write data
   input wire logic wrStb, // Write strobe
   input wire logic rdStb, // Read strobe
   output logic [7:0] rdData, // Read data, cycle after strobe
   input wire logic sckIn, // SCK pin level
   output logic sckOut, // SCK drive value
   output logic sckOe, // SCK drive enable
   input wire logic mosiIn, // MOSI pin level
   output logic mosiOut, // MOSI drive value
   output logic mosiOe, // MOSI drive enable
   input wire logic misoIn, // MISO pin level
   output logic misoOut, // MISO drive value
   output logic misoOe, // MISO drive enable
   input wire logic slaveSelectNIn, // Select pin level, active low
   output logic slaveSelectNOut, // Select drive value
   output logic slaveSelectNOe, // Select drive enable
   output logic irqReq // Interrupt request level
);

   // ==========================================================
   // Elaboration checks
   generate
      if (ADDR_W < 2) begin : g_bad_addr
         $error("ADDR_W must be at least 2");
      end
      if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
         $error("DIV_W must be 1 to 8");
      end
   endgenerate

   // ==========================================================
   // Pin synchronisers
   localparam int NSYNC = 4;
   logic [NSYNC-1:0] pinRaw;
   logic [NSYNC-1:0] syncA;
   logic [NSYNC-1:0] syncB;
   assign pinRaw = {sckIn, mosiIn, misoIn, slaveSelectNIn};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            // Reset to each pin's idle level so no false edge follows reset
            if (!rst_b) begin
               syncA[gi] <= (gi == 0);
               syncB[gi] <= (gi == 0);
            end else if (clkEn) begin
               syncA[gi] <= pinRaw[gi];
               syncB[gi] <= syncA[gi];
            end
         end
      end
   endgenerate

   logic sckS;
   logic mosiS;
   logic misoS;
   logic ssS;
   assign {sckS, mosiS, misoS, ssS} = syncB;

   // Selected as slave for a given select mode
   function automatic logic slaveSelected(input logic [1:0] mode, input logic selN);
      slaveSelected = (mode == `SPI_MODE_3WIRE) || ((mode == `SPI_MODE_MULTI) && !selN);
   endfunction

   // ==========================================================
   // State
   spi_port_pkg::flags_s flags, next_flags;
   spi_port_pkg::mstate_e mState, next_mState;
   logic [1:0] selMode, next_selMode;
   logic irqEn, next_irqEn;
   logic blockEn, next_blockEn;
   logic masterEn, next_masterEn;
   logic cpha, next_cpha;
   logic cpol, next_cpol;
   logic [DIV_W-1:0] rateDiv, next_rateDiv;
   logic [7:0] txBuf, next_txBuf;
   logic txFull, next_txFull;
   logic [7:0] shReg, next_shReg;
   logic shEmpty, next_shEmpty;
   logic [7:0] rxBuf, next_rxBuf;
   logic rxFull, next_rxFull;
   logic [3:0] bitCnt, next_bitCnt;
   logic rxBit, next_rxBit;
   logic pend, next_pend;
   logic [DIV_W-1:0] halfCnt, next_halfCnt;
   logic sckGen, next_sckGen;
   logic leadNext, next_leadNext;
   logic sckPrev, next_sckPrev;
   logic ssPrev, next_ssPrev;
   logic [7:0] next_rdData;
   logic next_sckOut, next_sckOe;
   logic next_mosiOut, next_mosiOe;
   logic next_misoOut, next_misoOe;
   logic next_ssOut, next_ssOe;
   logic next_irqReq;

   // Combinational helpers
   logic slaveActive;
   logic selFall;
   logic lead;
   logic trail;
   logic din;
   logic sampleEdge;
   logic shiftEdge;
   logic done;
   logic [7:0] captured;
   logic busy;

   // ==========================================================
   // Next-state logic
   always_comb begin
      next_flags = flags;
      next_mState = mState;
      next_selMode = selMode;
      next_irqEn = irqEn;
      next_blockEn = blockEn;
      next_masterEn = masterEn;
      next_cpha = cpha;
      next_cpol = cpol;
      next_rateDiv = rateDiv;
      next_txBuf = txBuf;
      next_txFull = txFull;
      next_shReg = shReg;
      next_shEmpty = shEmpty;
      next_rxBuf = rxBuf;
      next_rxFull = rxFull;
      next_bitCnt = bitCnt;
      next_rxBit = rxBit;
      next_pend = pend;
      next_halfCnt = halfCnt;
      next_sckGen = sckGen;
      next_leadNext = leadNext;
      next_sckPrev = sckS;
      next_ssPrev = ssS;
      done = 1'b0;
      captured = shReg;
      lead = 1'b0;
      trail = 1'b0;

      slaveActive = blockEn && !masterEn && slaveSelected(selMode, ssS);
      selFall = ssPrev && !ssS;

      // Register writes; flags clear on a written zero
      if (wrStb) begin
         case (regAddr[1:0])
            `SPI_ADDR_CTRL: begin
               next_flags.xferDone = flags.xferDone & wrData[`SPI_CTRL_DONE];
               next_flags.writeColl = flags.writeColl & wrData[`SPI_CTRL_WRITE_COLLISION_FLAG];
               next_flags.modeFault = flags.modeFault & wrData[`SPI_CTRL_MODE_FAULT_FLAG];
               next_flags.rxOverrun = flags.rxOverrun & wrData[`SPI_CTRL_OVRN];
               next_selMode = {wrData[`SPI_CTRL_MODE_HI], wrData[`SPI_CTRL_MODE_LO]};
               next_irqEn = wrData[`SPI_CTRL_IRQEN];
               next_blockEn = wrData[`SPI_CTRL_EN];
            end
            `SPI_ADDR_CFG: begin
               next_masterEn = wrData[`SPI_CFG_MASTER_ENABLE];
               next_cpha = wrData[`SPI_CFG_CPHA];
               next_cpol = wrData[`SPI_CFG_CPOL];
            end
            `SPI_ADDR_DATA: begin
               if (txFull) begin
                  next_flags.writeColl = 1'b1;
               end else begin
                  next_txBuf = wrData;
                  next_txFull = 1'b1;
               end
            end
            `SPI_ADDR_RATE: begin
               next_rateDiv = wrData[DIV_W-1:0];
            end
            default: begin
            end
         endcase
      end

      if (rdStb && regAddr[1:0] == `SPI_ADDR_DATA) begin
         next_rxFull = 1'b0;
      end

      // Master SCK generation, half period of rateDiv+1 clocks
      if (mState == spi_port_pkg::M_RUN) begin
         if (halfCnt == rateDiv) begin
            next_halfCnt = '0;
            next_sckGen = ~sckGen;
            next_leadNext = ~leadNext;
            lead = leadNext;
            trail = ~leadNext;
         end else begin
            next_halfCnt = halfCnt + 1'b1;
         end
      end else if (slaveActive) begin
         lead = (sckS != sckPrev) && (sckS != cpol);
         trail = (sckS != sckPrev) && (sckS == cpol);
      end

      din = masterEn ? misoS : mosiS;
      sampleEdge = cpha ? trail : lead;
      shiftEdge = cpha ? lead : trail;

      // Shift engine, MSB out first, new bit enters at the bottom
      if (sampleEdge) begin
         if (cpha && bitCnt == `SPI_BIT_LAST) begin
            captured = {shReg[6:0], din};
            done = 1'b1;
            next_shReg = captured;
            next_bitCnt = '0;
            next_pend = 1'b0;
         end else begin
            next_rxBit = din;
            next_pend = 1'b1;
            next_bitCnt = bitCnt + 1'b1;
         end
      end
      if (shiftEdge && pend) begin
         captured = {shReg[6:0], rxBit};
         next_shReg = captured;
         next_pend = 1'b0;
         if (!cpha && bitCnt == `SPI_BIT_FULL) begin
            done = 1'b1;
            next_bitCnt = '0;
         end
      end

      // Byte complete
      if (done) begin
         next_flags.xferDone = 1'b1;
         next_shEmpty = 1'b1;
         if (next_rxFull && !masterEn) begin
            next_flags.rxOverrun = 1'b1;
         end else begin
            next_rxBuf = captured;
            next_rxFull = 1'b1;
         end
         if (mState == spi_port_pkg::M_RUN) begin
            next_mState = spi_port_pkg::M_IDLE;
            next_sckGen = cpol;
         end
      end

      // Four-wire slave realigns on select fall
      if (!masterEn && selMode == `SPI_MODE_MULTI && selFall) begin
         next_bitCnt = '0;
         next_pend = 1'b0;
      end

      // Buffer to shift register when the shifter is empty
      if (next_txFull && next_shEmpty) begin
         next_shReg = next_txBuf;
         next_txFull = 1'b0;
         next_shEmpty = 1'b0;
         // Next state, so a queued byte starts right after the one just done
         if (blockEn && masterEn && next_mState == spi_port_pkg::M_IDLE) begin
            next_mState = spi_port_pkg::M_RUN;
            next_halfCnt = '0;
            next_leadNext = 1'b1;
            next_sckGen = cpol;
         end
      end

      // Disabled port drops any partial byte
      if (!blockEn) begin
         next_bitCnt = '0;
         next_pend = 1'b0;
         next_mState = spi_port_pkg::M_IDLE;
         next_sckGen = cpol;
      end

      // Another master took the bus
      if (blockEn && masterEn && selMode == `SPI_MODE_MULTI && selFall) begin
         next_masterEn = 1'b0;
         next_blockEn = 1'b0;
         next_flags.modeFault = 1'b1;
         next_mState = spi_port_pkg::M_IDLE;
         next_sckGen = cpol;
         next_bitCnt = '0;
         next_pend = 1'b0;
      end
   end

   // ==========================================================
   // Read data and pin outputs, all registered
   always_comb begin
      busy = (mState == spi_port_pkg::M_RUN) || (bitCnt != 4'h0) || pend;
      next_rdData = 8'h00;
      if (rdStb) begin
         case (regAddr[1:0])
            `SPI_ADDR_CTRL: begin
               next_rdData = {flags, selMode, irqEn, blockEn};
            end
            `SPI_ADDR_CFG: begin
               next_rdData = {busy, masterEn, cpha, cpol, slaveActive, ssS, shEmpty, ~rxFull};
            end
            `SPI_ADDR_DATA: begin
               next_rdData = rxBuf;
            end
            `SPI_ADDR_RATE: begin
               next_rdData = 8'(rateDiv);
            end
            default: begin
               next_rdData = 8'h00;
            end
         endcase
      end
      next_mosiOut = shReg[7];
      next_mosiOe = blockEn && masterEn;
      next_sckOut = masterEn ? sckGen : cpol;
      next_sckOe = blockEn && masterEn;
      next_misoOut = shReg[7];
      next_misoOe = blockEn && !masterEn && slaveSelected(selMode, ssS);
      next_ssOut = selMode[0];
      next_ssOe = selMode[1];
      next_irqReq = irqEn && (|flags);
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flags <= '0;
         mState <= spi_port_pkg::M_IDLE;
         selMode <= `SPI_MODE_RESET;
         irqEn <= 1'b0;
         blockEn <= 1'b0;
         masterEn <= 1'b0;
         cpha <= 1'b0;
         cpol <= 1'b0;
         rateDiv <= DIV_W'(`SPI_RATE_RESET);
         txBuf <= `SPI_BYTE_RESET;
         txFull <= 1'b0;
         shReg <= `SPI_BYTE_RESET;
         shEmpty <= 1'b1;
         rxBuf <= `SPI_BYTE_RESET;
         rxFull <= 1'b0;
         bitCnt <= '0;
         rxBit <= 1'b0;
         pend <= 1'b0;
         halfCnt <= '0;
         sckGen <= 1'b0;
         leadNext <= 1'b1;
         sckPrev <= 1'b0;
         ssPrev <= 1'b1;
         rdData <= 8'h00;
         sckOut <= 1'b0;
         sckOe <= 1'b0;
         mosiOut <= 1'b0;
         mosiOe <= 1'b0;
         misoOut <= 1'b0;
         misoOe <= 1'b0;
         slaveSelectNOut <= 1'b1;
         slaveSelectNOe <= 1'b0;
         irqReq <= 1'b0;
      end else if (clkEn) begin
         flags <= next_flags;
         mState <= next_mState;
         selMode <= next_selMode;
         irqEn <= next_irqEn;
         blockEn <= next_blockEn;
         masterEn <= next_masterEn;
         cpha <= next_cpha;
         cpol <= next_cpol;
         rateDiv <= next_rateDiv;
         txBuf <= next_txBuf;
         txFull <= next_txFull;
         shReg <= next_shReg;
         shEmpty <= next_shEmpty;
         rxBuf <= next_rxBuf;
         rxFull <= next_rxFull;
         bitCnt <= next_bitCnt;
         rxBit <= next_rxBit;
         pend <= next_pend;
         halfCnt <= next_halfCnt;
         sckGen <= next_sckGen;
         leadNext <= next_leadNext;
         sckPrev <= next_sckPrev;
         ssPrev <= next_ssPrev;
         rdData <= next_rdData;
         sckOut <= next_sckOut;
         sckOe <= next_sckOe;
         mosiOut <= next_mosiOut;
         mosiOe <= next_mosiOe;
         misoOut <= next_misoOut;
         misoOe <= next_misoOe;
         slaveSelectNOut <= next_ssOut;
         slaveSelectNOe <= next_ssOe;
         irqReq <= next_irqReq;
      end
   end

endmodule // spi_master_slave_port

// File: verif/spi_port_sva.sv
`timescale 1ns/1ns
module spi_port_sva (
   input wire logic core_clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic wrStb, // Write strobe
   input wire logic rdStb, // Read strobe
   input wire logic [7:0] rdData, // Read data
   input wire logic sckOe, // SCK enable
   input wire logic mosiOe, // MOSI enable
   input wire logic misoOe, // MISO enable
   input wire logic slaveSelectNIn, // Select level
   input wire logic slaveSelectNOe, // Select enable
   input wire logic irqReq // Interrupt
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // Pin ownership
   property p_mosi_sck; mosiOe |-> sckOe; endproperty
   a_mosi_sck: assert property (p_mosi_sck) else $error("mosi without sck");
   property p_miso_mst; sckOe |-> !misoOe; endproperty
   a_miso_mst: assert property (p_miso_mst) else $error("miso as master");
   property p_slv_mosi; !sckOe |-> !mosiOe; endproperty
   a_slv_mosi: assert property (p_slv_mosi) else $error("slave drove mosi");
   property p_sel_miso; slaveSelectNOe |-> !misoOe; endproperty
   a_sel_miso: assert property (p_sel_miso) else $error("miso in mode 1x");
   // Select output only ever follows a register write
   property p_sel_en; $rose(slaveSelectNOe) |-> $past(wrStb) || $past(wrStb, 2); endproperty
   a_sel_en: assert property (p_sel_en) else $error("select out unasked");
   // ==========================================================
   // Events
   property p_fault;
      sckOe && !slaveSelectNOe && $fell(slaveSelectNIn) |-> ##[1:8] !sckOe;
   endproperty
   a_fault: assert property (p_fault) else $error("no mode fault");
   property p_irq_sw; $fell(irqReq) |-> $past(wrStb) || $past(wrStb, 2); endproperty
   a_irq_sw: assert property (p_irq_sw) else $error("flag cleared by hw");
   property p_rd_zero; !$past(rdStb) |-> rdData == 8'h00; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
endmodule // spi_port_sva

bind spi_master_slave_port spi_port_sva u_sva (.*);

// File: verif/spi_far_end.sv
`timescale 1ns/1ns
module spi_far_end (
   input wire logic mst, // High: act as master
   input wire logic sckIn, // Resolved SCK
   input wire logic mosiIn, // Resolved MOSI
   input wire logic misoIn, // Resolved MISO
   input wire logic hostSck, // Block drives SCK
   output logic misoDrv, // Slave data
   output logic sckDrv, // Master clock
   output logic mosiDrv, // Master data
   output logic mosiEn, // Master data enable
   output logic selDrv, // Select, active low
   output logic selEn // Select enable
);
   localparam int HALF = 250;
   logic [15:0] sTx = 16'h0000;
   logic [15:0] sRx = 16'h0000;
   logic [7:0] mRx = 8'h00;
   int sCnt = 0;
   initial begin
      sckDrv = 1'b0;
      mosiDrv = 1'b0;
      mosiEn = 1'b0;
      selDrv = 1'b1;
      selEn = 1'b0;
   end
   // ==========================================================
   // Slave role, clock phase 0, polarity 0
   assign misoDrv = sTx[15];
   always @(posedge sckIn) begin
      if (!mst && hostSck) begin
         sRx <= {sRx[14:0], mosiIn};
         sCnt <= sCnt + 1;
      end
   end
   always @(negedge sckIn) begin
      if (!mst && hostSck) begin
         sTx <= {sTx[14:0], 1'b0};
      end
   end
   // ==========================================================
   // Master role
   task automatic xfer(input logic [7:0] d, input logic pol, input logic pha, input logic sel);
      #13;
      sckDrv = pol;
      selEn = sel;
      selDrv = 1'b0;
      mosiEn = 1'b1;
      #300;
      for (int i = 7; i >= 0; i--) begin
         if (pha) sckDrv = ~pol;
         mosiDrv = d[i];
         #HALF;
         mRx = {mRx[6:0], misoIn};
         sckDrv = ~sckDrv;
         #HALF;
         if (!pha) sckDrv = pol;
      end
      #300;
      selDrv = 1'b1;
      selEn = 1'b0;
      mosiEn = 1'b0;
      #300;
   endtask
   // Rival master grabs the bus
   task automatic selPulse();
      #13;
      selEn = 1'b1;
      selDrv = 1'b0;
      #500;
      selEn = 1'b0;
      #500;
   endtask
endmodule // spi_far_end

// File: verif/tb_spi_master_slave_port.sv
`timescale 1ns/1ns
`include "spi_port_defines.svh"
module tb_spi_master_slave_port;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] wrData = 8'h00;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic farMaster = 1'b0;
   logic junk = 1'b0;
   logic [7:0] rdData, got;
   logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, irqReq;
   logic slaveSelectNOut, slaveSelectNOe;
   logic fSck, fMosi, fMosiEn, fMiso, fSel, fSelEn;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   // Undriven lines toggle so a stale level cannot pass; select has a pull-up
   wire sckIn = sckOe ? sckOut : (farMaster ? fSck : junk);
   wire mosiIn = mosiOe ? mosiOut : (fMosiEn ? fMosi : junk);
   wire misoIn = misoOe ? misoOut : (!farMaster ? fMiso : junk);
   wire slaveSelectNIn = slaveSelectNOe ? slaveSelectNOut : (fSelEn ? fSel : 1'b1);
   spi_master_slave_port u_dut (.core_clk, .rst_b, .clkEn(1'b1), .regAddr, .wrData, .wrStb,
      .rdStb, .rdData, .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut,
      .misoOe, .slaveSelectNIn, .slaveSelectNOut, .slaveSelectNOe, .irqReq);
   spi_far_end u_far (.mst(farMaster), .sckIn, .mosiIn, .misoIn, .hostSck(sckOe),
      .misoDrv(fMiso), .sckDrv(fSck), .mosiDrv(fMosi), .mosiEn(fMosiEn), .selDrv(fSel),
      .selEn(fSelEn));
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) junk <= ~junk;
   // ==========================================================
   // Tasks
   task automatic finish_test();
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge core_clk);
      wrStb <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      rdStb <= 1'b1;
      @(posedge core_clk);
      rdStb <= 1'b0;
      #1;
      d = rdData;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdChk(input logic [1:0] a, input logic [7:0] e, input string nm);
      rd(a, got);
      chk(nm, e, got);
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   // ==========================================================
   // Sequence
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      rdChk(`SPI_ADDR_CTRL, 8'h04, "ctrl reset");
      rdChk(`SPI_ADDR_CFG, 8'h07, "cfg reset");
      // Master, two queued bytes and a colliding third
      u_far.sTx = 16'hc33c;
      wr(`SPI_ADDR_RATE, 8'h04);
      wr(`SPI_ADDR_CFG, 8'h40);
      wr(`SPI_ADDR_CTRL, 8'h0f);
      repeat (3) @(posedge core_clk);
      chk("select high", 8'h01, {7'h00, slaveSelectNOut});
      wr(`SPI_ADDR_DATA, 8'ha5);
      repeat (4) @(posedge core_clk);
      wr(`SPI_ADDR_DATA, 8'h5b);
      wr(`SPI_ADDR_DATA, 8'hff);
      for (int i = 0; i < 2000 && u_far.sCnt < 16; i++) @(posedge core_clk);
      for (int i = 0; i < 50; i++) begin
         rd(`SPI_ADDR_CFG, got);
         if (got[`SPI_CFG_BUSY] === 1'b0) break;
      end
      chk("far byte 1", 8'ha5, u_far.sRx[15:8]);
      chk("far byte 2", 8'h5b, u_far.sRx[7:0]);
      rdChk(`SPI_ADDR_CTRL, 8'hcf, "done write_collision_flag");
      chk("irq", 8'h01, {7'h00, irqReq});
      rdChk(`SPI_ADDR_DATA, 8'h3c, "master rx");
      wr(`SPI_ADDR_CTRL, 8'h0b);
      repeat (3) @(posedge core_clk);
      chk("select low", 8'h00, {7'h00, slaveSelectNOut});
      chk("irq cleared", 8'h00, {7'h00, irqReq});
      // Rival master pulls select
      wr(`SPI_ADDR_CTRL, 8'h07);
      repeat (6) @(posedge core_clk);
      u_far.selPulse();
      rdChk(`SPI_ADDR_CTRL, 8'h26, "mode fault");
      rdChk(`SPI_ADDR_CFG, 8'h07, "master off");
      // Four-wire slave
      farMaster = 1'b1;
      wr(`SPI_ADDR_CFG, 8'h00);
      wr(`SPI_ADDR_CTRL, 8'h05);
      wr(`SPI_ADDR_DATA, 8'h96);
      u_far.xfer(8'h5a, 1'b0, 1'b0, 1'b1);
      chk("slave tx", 8'h96, u_far.mRx);
      rdChk(`SPI_ADDR_CTRL, 8'h85, "slave done");
      rdChk(`SPI_ADDR_DATA, 8'h5a, "slave rx");
      wr(`SPI_ADDR_CTRL, 8'h05);
      u_far.xfer(8'h11, 1'b0, 1'b0, 1'b0);
      rdChk(`SPI_ADDR_CTRL, 8'h05, "unselected");
      u_far.xfer(8'h11, 1'b0, 1'b0, 1'b1);
      u_far.xfer(8'h22, 1'b0, 1'b0, 1'b1);
      rdChk(`SPI_ADDR_CTRL, 8'h95, "overrun");
      rdChk(`SPI_ADDR_DATA, 8'h11, "kept byte");
      // Three-wire slave, phase 1, polarity 1
      wr(`SPI_ADDR_CTRL, 8'h00);
      wr(`SPI_ADDR_CFG, 8'h30);
      u_far.sckDrv = 1'b1;
      wr(`SPI_ADDR_CTRL, 8'h01);
      wr(`SPI_ADDR_DATA, 8'h6e);
      repeat (3) @(posedge core_clk);
      chk("miso driven", 8'h01, {7'h00, misoOe});
      u_far.xfer(8'hc7, 1'b1, 1'b1, 1'b0);
      chk("3w tx", 8'h6e, u_far.mRx);
      rdChk(`SPI_ADDR_CTRL, 8'h81, "3w done");
      rdChk(`SPI_ADDR_DATA, 8'hc7, "3w rx");
      finish_test();
   end
endmodule // tb_spi_master_slave_port
